// ===== charge_pkg.sv
package charge_pkg;
  localparam int OSC_HZ        = 800;
  // Oscillator ticks per period; 20.48 s is 16384 ticks
  localparam int CYCLE_TICKS   = 16384;
  localparam int BREAK_TICKS   = 2048;
  localparam int PULSE_TICKS   = 4096;
  localparam int MEAS_START    = 1024;
  localparam int MIN5_CYCLES   = 15;
  localparam int MIN10_CYCLES  = 30;
  localparam int TOPOFF_CYCLES = 59;
  localparam int TRICKLE_DIV   = 64;
  localparam int BLINK_BIT     = 9;
  localparam logic [9:0] REF_CODE  = 10'h0f6;
  localparam logic [9:0] DROP_CODE = 10'h002;
  localparam logic [3:0] SLOPE_LSB = 4'h2;
  localparam logic [1:0] DROP_RUN  = 2'h3;

  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_PREFORM = 3'b001,
    ST_FAST    = 3'b010,
    ST_TOPOFF  = 3'b011,
    ST_TRICKLE = 3'b100
  } charge_state_t;

  typedef struct packed
  {
    logic charge_on;
    logic charge_break_output;
    logic red_status_indicator;
    logic green_status_indicator;
  } drive_t;
endpackage

// ===== fast_charge_sequencer.sv
`timescale 1ns/10ps
module fast_charge_sequencer
  import charge_pkg::*;
#(
  parameter int CYCLE_LEN = CYCLE_TICKS
)
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       osc_tick,
  input  wire logic       battery_removed,
  input  wire logic [9:0] battery_sample,
  input  wire logic       sample_valid,
  output drive_t          drive
);
  initial
  begin
    if (CYCLE_LEN < 64) $error("CYCLE_LEN too small");
  end

  localparam int BRK = CYCLE_LEN / 8;
  localparam int PLS = CYCLE_LEN / 4;
  // Blink rate scales with the period so short test periods still blink
  localparam int BLINK_POS = BLINK_BIT + $clog2(CYCLE_LEN) - $clog2(CYCLE_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage is read only by the second
  logic tick_s1_q, tick_s2_q, tick_s3_q;
  logic rem_s1_q, rem_s2_q, rem_s3_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      rem_s1_q  <= 1'b1;
      rem_s2_q  <= 1'b1;
      rem_s3_q  <= 1'b1;
    end
    else
    begin
      tick_s1_q <= osc_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      rem_s1_q  <= battery_removed;
      rem_s2_q  <= rem_s1_q;
      rem_s3_q  <= rem_s2_q;
    end
  end
  wire tick     = tick_s2_q & ~tick_s3_q;
  wire removed  = rem_s2_q;
  wire inserted = rem_s3_q & ~rem_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Period timing from oscillator ticks
  logic [15:0] tick_cnt_q;
  logic [7:0]  cyc_cnt_q;
  logic [5:0]  trk_cnt_q;
  wire         cyc_end = tick & (tick_cnt_q == 16'(CYCLE_LEN - 1));
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_cnt_q <= 16'h0000;
    else if (removed || inserted)
      tick_cnt_q <= 16'h0000;
    else if (cyc_end)
      tick_cnt_q <= 16'h0000;
    else if (tick)
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end
  wire in_break = tick_cnt_q < 16'(BRK);
  wire in_pulse = ~in_break & (tick_cnt_q < 16'(BRK + PLS));

  charge_state_t state_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_cnt_q <= 8'h00;
      trk_cnt_q <= 6'h00;
    end
    else if (removed || inserted)
    begin
      cyc_cnt_q <= 8'h00;
      trk_cnt_q <= 6'h00;
    end
    else if (cyc_end)
    begin
      cyc_cnt_q <= (cyc_cnt_q == 8'hff) ? cyc_cnt_q : cyc_cnt_q + 8'h01;
      trk_cnt_q <= (trk_cnt_q == 6'(TRICKLE_DIV - 1)) ? 6'h00 : trk_cnt_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage drop tracking
  logic [9:0] peak_q;
  logic [1:0] drop_run_q;
  logic       meas_q;
  wire        take = sample_valid & in_break & ~meas_q;
  wire        drop = take & (battery_sample + DROP_CODE <= peak_q)
                     & (peak_q >= DROP_CODE);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      meas_q <= 1'b0;
    else if (cyc_end || inserted)
      meas_q <= 1'b0;
    else if (take)
      meas_q <= 1'b1;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      peak_q     <= 10'h000;
      drop_run_q <= 2'h0;
    end
    else if (inserted || removed)
    begin
      peak_q     <= 10'h000;
      drop_run_q <= 2'h0;
    end
    else if (take)
    begin
      if (battery_sample > peak_q)
        peak_q <= battery_sample;
      if (drop)
        drop_run_q <= (drop_run_q == DROP_RUN) ? drop_run_q : drop_run_q + 2'h1;
      else
        drop_run_q <= 2'h0;
    end
  end
  wire drop_valid = drop_run_q == DROP_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // Slope counter: up eight samples, down eight, compare with -SLOPE_LSB
  logic [3:0] slope_q;
  logic [9:0] prev_q;
  logic [3:0] phase_q;
  logic       slope_hit_q;
  wire  [9:0] rise = battery_sample - prev_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slope_q     <= 4'h0;
      prev_q      <= 10'h000;
      phase_q     <= 4'h0;
      slope_hit_q <= 1'b0;
    end
    else if (inserted || removed)
    begin
      slope_q     <= 4'h0;
      prev_q      <= 10'h000;
      phase_q     <= 4'h0;
      slope_hit_q <= 1'b0;
    end
    else if (take)
    begin
      prev_q  <= battery_sample;
      phase_q <= phase_q + 4'h1;
      if (phase_q[3])
        slope_q <= slope_q - rise[3:0];
      else
        slope_q <= slope_q + rise[3:0];
      slope_hit_q <= (phase_q == 4'hf) &&
                     ($signed(slope_q - rise[3:0]) < -$signed(SLOPE_LSB));
    end
  end
  // Rising curvature shows as later rises exceeding earlier ones
  wire slope_armed = cyc_cnt_q >= 8'(MIN5_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Charge state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= ST_IDLE;
    else if (removed)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (take)
            state_q <= (battery_sample > REF_CODE) ? ST_FAST : ST_PREFORM;
        ST_PREFORM:
          if (take && battery_sample > REF_CODE)
            state_q <= ST_FAST;
        ST_FAST:
          if (drop_valid || (slope_armed && slope_hit_q))
            state_q <= ST_TOPOFF;
        ST_TOPOFF:
          if (cyc_end && phase_cyc_q >= 8'(TOPOFF_CYCLES))
            state_q <= ST_TRICKLE;
        ST_TRICKLE:
          state_q <= ST_TRICKLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Top-off time counts from its own entry
  logic [7:0] phase_cyc_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_cyc_q <= 8'h00;
    else if (state_q != ST_PREFORM && state_q != ST_TOPOFF)
      phase_cyc_q <= 8'h00;
    else if (cyc_end && phase_cyc_q != 8'hff)
      phase_cyc_q <= phase_cyc_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from state, period position, blink and the phase and trickle counters
  wire blink = tick_cnt_q[BLINK_POS];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      drive <= '0;
    else
    begin
      // No pack, no break strobe: all outputs rest low
      drive.charge_break_output <= in_break & ~removed;
      case (state_q)
        ST_PREFORM:
        begin
          drive.charge_on              <= ~in_break;
          drive.green_status_indicator <= (phase_cyc_q < 8'(MIN10_CYCLES)) & blink;
          drive.red_status_indicator   <= (phase_cyc_q >= 8'(MIN10_CYCLES)) & blink;
        end
        ST_FAST:
        begin
          drive.charge_on              <= ~in_break;
          drive.green_status_indicator <= blink;
          drive.red_status_indicator   <= 1'b0;
        end
        ST_TOPOFF:
        begin
          drive.charge_on              <= in_pulse;
          drive.green_status_indicator <= 1'b1;
          drive.red_status_indicator   <= 1'b0;
        end
        ST_TRICKLE:
        begin
          drive.charge_on              <= in_pulse & (trk_cnt_q == 6'h00);
          drive.green_status_indicator <= 1'b1;
          drive.red_status_indicator   <= 1'b0;
        end
        default:
        begin
          drive.charge_on              <= 1'b0;
          drive.green_status_indicator <= 1'b0;
          drive.red_status_indicator   <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence removal_s;
    removed;
  endsequence

  idle_after_removal_a: assert property (@(posedge clk) disable iff (!rstn)
    removal_s |=> state_q == ST_IDLE)
    else $error("state not idle after removal");
  no_charge_break_a: assert property (@(posedge clk) disable iff (!rstn)
    in_break |=> !drive.charge_on)
    else $error("charge during break");
  low_goes_preform_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_IDLE && !removed && take && battery_sample <= REF_CODE)
      |=> state_q == ST_PREFORM)
    else $error("low battery not preformed");
  high_goes_fast_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_IDLE && !removed && take && battery_sample > REF_CODE)
      |=> state_q == ST_FAST)
    else $error("high battery not fast");
  slope_early_block_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_FAST && !slope_armed && !drop_valid && !removed) |=> state_q == ST_FAST)
    else $error("early slope stop");
  drop_ends_fast_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_FAST && drop_valid && !removed) |=> state_q == ST_TOPOFF)
    else $error("drop did not stop fast");
  trickle_holds_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_TRICKLE && !removed) |=> state_q == ST_TRICKLE)
    else $error("trickle left");
  red_after_ten_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == ST_PREFORM && phase_cyc_q < 8'(MIN10_CYCLES)) |=> !drive.red_status_indicator)
    else $error("red too early");
endmodule

// ===== pack_model.sv
`timescale 1ns/10ps
module pack_model
  import charge_pkg::*;
(
  input  wire logic       clk,
  input  wire drive_t     drive,
  input  wire logic [9:0] level,
  input  wire logic       present,
  output logic            battery_removed,
  output logic [9:0]      battery_sample,
  output logic            sample_valid
);
  logic       brk_q;
  logic [2:0] wait_q;

  initial
  begin
    battery_removed = 1'b1;
    battery_sample  = 10'h000;
    sample_valid    = 1'b0;
    brk_q           = 1'b0;
    wait_q          = 3'h0;
  end

  ////////////////////////////////////////////////////////////
  // Converter output is only valid in its strobe cycle; toggles otherwise
  always @(posedge clk)
  begin
    #2;
    battery_removed = !present;
    sample_valid    = 1'b0;
    battery_sample  = ~battery_sample;
    if (drive.charge_break_output && !brk_q)
      wait_q = 3'h4;
    else if (wait_q != 3'h0)
    begin
      wait_q = wait_q - 3'h1;
      if (wait_q == 3'h1)
      begin
        sample_valid   = 1'b1;
        battery_sample = level;
      end
    end
    brk_q = drive.charge_break_output;
  end
endmodule

// ===== test_fast_charge_sequencer.sv
`timescale 1ns/10ps
module test_fast_charge_sequencer
  import charge_pkg::*;
  ;
  // One period is 64 ticks of 4 clocks each
  localparam int PER = 256;
  logic       clk;
  logic       rstn;
  logic       osc_tick;
  logic [1:0] osc_div;
  logic       present;
  logic [9:0] level;
  logic       battery_removed;
  logic [9:0] battery_sample;
  logic       sample_valid;
  drive_t     drive;
  int         num_errors;
  int         n_compared;
  int         cycles;
  int         on_cnt;
  int         red_hi;
  int         green_hi;
  int         green_tog;
  int         k;

  fast_charge_sequencer #(.CYCLE_LEN(64)) dut (.clk(clk), .rstn(rstn), .osc_tick(osc_tick),
    .battery_removed(battery_removed), .battery_sample(battery_sample),
    .sample_valid(sample_valid), .drive(drive));

  pack_model pack (.clk(clk), .drive(drive), .level(level), .present(present),
    .battery_removed(battery_removed), .battery_sample(battery_sample),
    .sample_valid(sample_valid));

  initial
  begin
    clk = 1'b0; rstn = 1'b0; osc_tick = 1'b0; osc_div = 2'h0;
    present = 1'b0; level = 10'h000; num_errors = 0; n_compared = 0; cycles = 0;
  end

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    #2;
    osc_div = osc_div + 2'h1;
    if (osc_div[0] == 1'b0)
      osc_tick = ~osc_tick;
  end

  // Slowest path is about 200 periods
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 80000)
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Gathers indicator and charge activity over n whole periods
  task automatic watch(input int n);
    logic g;
    on_cnt = 0; red_hi = 0; green_hi = 0; green_tog = 0;
    g = drive.green_status_indicator;
    repeat (n * PER)
    begin
      @(posedge clk);
      on_cnt = on_cnt + int'(drive.charge_on === 1'b1);
      red_hi = red_hi + int'(drive.red_status_indicator === 1'b1);
      green_hi = green_hi + int'(drive.green_status_indicator === 1'b1);
      green_tog = green_tog + int'(drive.green_status_indicator !== g);
      g = drive.green_status_indicator;
    end
  endtask

  // 2 fast, 1 pulsed, 0 idle, measured over the periods of the last watch
  function automatic logic [9:0] rate();
    return (on_cnt > 160) ? 10'h2 : (on_cnt > 0) ? 10'h1 : 10'h0;
  endfunction

  task automatic insert(input logic [9:0] v);
    @(posedge clk);
    #2;
    present = 1'b0;
    repeat (20) @(posedge clk);
    chk(10'(drive), 10'h0);
    #2;
    level = v;
    present = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_drop();
    insert(10'h200);
    watch(2);
    chk(rate(), 10'h2);
    level = 10'h1ff;
    watch(4);
    chk(rate(), 10'h2);
    level = 10'h1fe;
    watch(2);
    chk(rate(), 10'h2);
    watch(2);
    chk(10'(rate() != 10'h2), 10'h1);
  endtask

  task automatic t_preform();
    insert(10'h0f0);
    watch(28);
    chk(10'(green_tog > 0 && red_hi == 0), 10'h1);
    watch(4);
    watch(16);
    chk(10'(red_hi > 0 && green_hi == 0), 10'h1);
    chk(10'(on_cnt > 0), 10'h1);
    level = 10'h150;
    watch(2);
    watch(1);
    chk(rate(), 10'h2);
    chk(10'(red_hi), 10'h0);
  endtask

  // Accelerating rise trips slope only once monitoring is enabled
  task automatic t_slope();
    insert(10'h100);
    k = 0;
    do
    begin
      level = level + 10'(k / 8);
      watch(1);
      if (k == 13)
        chk(rate(), 10'h2);
      k = k + 1;
    end
    while (rate() == 10'h2 && k < 40);
    chk(rate(), 10'h1);
    chk(10'(on_cnt > 32 && on_cnt < 96), 10'h1);
    k = 0;
    do
    begin
      watch(1);
      k = k + 1;
    end
    while (rate() == 10'h1 && k < 70);
    chk(10'(k >= 57 && k <= 61), 10'h1);
    watch(64);
    chk(10'(on_cnt > 0 && on_cnt <= 128), 10'h1);
    @(posedge clk);
    #2;
    present = 1'b0;
    repeat (10) @(posedge clk);
    chk(10'(drive), 10'h0);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    chk(10'(drive), 10'h0);
    #2;
    rstn = 1'b1;
    t_drop();
    t_preform();
    t_slope();
    report_and_stop();
  end
endmodule
